/* File: hdl/sfr_map_pkg.sv */
// Special function register map constants: addresses, reset values, field positions.
// Assumes an 8-bit core issuing direct-address byte and bit accesses on one clock.
//
// Contract
// (RQ1) Registers reached only by direct address 80h-FFh
// (RQ2) Sixteen addresses also bit-addressable, rest byte-only
// (RQ3) Software never writes unoccupied reserved addresses
// (RQ4) Reserved address reads return undefined data
// (RQ5) No control over programmable-logic module functions
// (RQ6) Implemented registers load listed reset values
// (RQ7) Timer control bits map to 88h-8Fh
// (RQ8) Stack pointer resets to 07h
`default_nettype none

package sfr_map_pkg;

   // ***************************************************
   // Addresses
   // ***************************************************
   localparam logic [7:0] ADDR_STACK_POINTER       = 8'h81;
   localparam logic [7:0] ADDR_DATA_POINTER_LOW    = 8'h82;
   localparam logic [7:0] ADDR_DATA_POINTER_HIGH   = 8'h83;
   localparam logic [7:0] ADDR_POINTER_SELECT_CTL  = 8'h85;
   localparam logic [7:0] ADDR_POINTER_STEP_MODE   = 8'h86;
   localparam logic [7:0] ADDR_POWER_CONTROL       = 8'h87;
   localparam logic [7:0] ADDR_TIMER_CONTROL       = 8'h88;
   localparam logic [7:0] ADDR_TIMER_MODE          = 8'h89;
   localparam logic [7:0] ADDR_TIMER0_COUNT_LOW    = 8'h8A;
   localparam logic [7:0] ADDR_TIMER1_COUNT_LOW    = 8'h8B;
   localparam logic [7:0] ADDR_TIMER0_COUNT_HIGH   = 8'h8C;
   localparam logic [7:0] ADDR_TIMER1_COUNT_HIGH   = 8'h8D;
   localparam logic [7:0] ADDR_PORT1_FSEL_A        = 8'h8E;
   localparam logic [7:0] ADDR_PORT1_FSEL_B        = 8'h8F;
   localparam logic [7:0] ADDR_PORT1_PINS          = 8'h90;
   localparam logic [7:0] ADDR_PORT3_FSEL          = 8'h91;
   localparam logic [7:0] ADDR_PORT4_FSEL_A        = 8'h92;
   localparam logic [7:0] ADDR_PORT4_FSEL_B        = 8'h93;

   // ***************************************************
   // Reset values and writable masks
   // ***************************************************
   localparam logic [7:0] RST_STACK_POINTER        = 8'h07;
   localparam logic [7:0] RST_ZERO                 = 8'h00;
   localparam logic [7:0] RST_PORT1_LATCH          = 8'hFF;
   localparam logic [7:0] RESERVED_READ            = 8'h00;
   localparam logic [7:0] MASK_ALL                 = 8'hFF;
   localparam logic [7:0] MASK_POINTER_SELECT      = 8'h47;
   localparam logic [7:0] MASK_POINTER_STEP        = 8'h0F;
   localparam logic [7:0] MASK_POWER_CONTROL       = 8'hDF;

   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int TC_TIMER1_OVERFLOW = 7;
   localparam int TC_TIMER0_OVERFLOW = 5;
   localparam int TC_EXT_INT1_FLAG   = 3;
   localparam int TC_EXT_INT1_TYPE   = 2;
   localparam int TC_EXT_INT0_FLAG   = 1;
   localparam int TC_EXT_INT0_TYPE   = 0;
   localparam int PC_POWER_ON_FLAG   = 4;
   localparam int PC_POWER_DOWN      = 1;
   localparam int PC_IDLE            = 0;

   // Byte that owns a bit address
   function automatic logic [7:0] bit_owner(input logic [7:0] bit_addr);
      return {bit_addr[7:3], 3'h0};
   endfunction : bit_owner

   // Direct address lies in the register window
   function automatic logic in_window(input logic [7:0] addr);
      return addr[7];
   endfunction : in_window

   function automatic logic is_implemented(input logic [7:0] addr);
      return (addr >= ADDR_STACK_POINTER && addr <= ADDR_PORT4_FSEL_B)
             && addr != 8'h84;
   endfunction : is_implemented

endpackage : sfr_map_pkg

`default_nettype wire

/* File: hdl/sfr_flag_reg.sv */
// One register byte with byte write, bit write and hardware set/clear.
// Assumes byte and bit write do not collide; byte write wins if they do.
`timescale 1ns/1ps
`default_nettype none

module sfr_flag_reg #(
   parameter logic [7:0] RESET_VALUE = 8'h00,
   parameter logic [7:0] WRITE_MASK  = 8'hFF
) (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       byte_we,
   input  wire logic [7:0] byte_wdata,
   input  wire logic       bit_we,
   input  wire logic [2:0] bit_sel,
   input  wire logic       bit_wdata,
   input  wire logic [7:0] hw_set,
   input  wire logic [7:0] hw_clr,
   output var  logic [7:0] value_q
);

   logic [7:0] bit_one;
   logic [7:0] bit_merged;
   logic [7:0] write_src;
   logic [7:0] sw_d;
   logic [7:0] value_d;

   assign bit_one    = 8'h01 << bit_sel;
   assign bit_merged = (value_q & ~bit_one) | (bit_wdata ? bit_one : 8'h00);
   assign write_src  = byte_we ? byte_wdata : bit_merged;
   assign sw_d       = (byte_we || bit_we)
                       ? ((write_src & WRITE_MASK) | (value_q & ~WRITE_MASK))
                       : value_q;
   // Hardware set applied last so an event beats a clear in the same cycle
   assign value_d    = (sw_d & ~hw_clr) | hw_set;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         value_q <= RESET_VALUE;
      end else begin
         value_q <= value_d;
      end
   end

endmodule : sfr_flag_reg

`default_nettype wire

/* File: hdl/sfr_bank.sv */
// Special function register bank of the core: direct byte and bit access.
// Assumes one core access per cycle, all strobes on clock; port pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none

module sfr_bank (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_rd,
   input  wire logic       sfr_wr,
   input  wire logic [7:0] sfr_wdata,
   output var  logic [7:0] sfr_rdata,
   output var  logic       sfr_hit,
   input  wire logic [7:0] bit_addr,
   input  wire logic       bit_rd,
   input  wire logic       bit_wr,
   input  wire logic       bit_wdata,
   output var  logic       bit_rdata,
   output var  logic       bit_hit,
   input  wire logic       timer0_overflow,
   input  wire logic       timer1_overflow,
   input  wire logic       ext_int0_event,
   input  wire logic       ext_int1_event,
   input  wire logic       ext_int0_ack,
   input  wire logic       ext_int1_ack,
   input  wire logic       power_on_event,
   input  wire logic       wake_event,
   input  wire logic [7:0] port1_pins_in,
   output var  logic [7:0] stack_pointer,
   output var  logic [7:0] data_pointer_low,
   output var  logic [7:0] data_pointer_high,
   output var  logic [7:0] pointer_select_control,
   output var  logic [7:0] pointer_step_mode,
   output var  logic [7:0] power_control,
   output var  logic [7:0] timer_control,
   output var  logic [7:0] timer_mode,
   output var  logic [7:0] timer0_count_low,
   output var  logic [7:0] timer1_count_low,
   output var  logic [7:0] timer0_count_high,
   output var  logic [7:0] timer1_count_high,
   output var  logic [7:0] port1_function_select_a,
   output var  logic [7:0] port1_function_select_b,
   output var  logic [7:0] port1_latch,
   output var  logic [7:0] port3_function_select,
   output var  logic [7:0] port4_function_select_a,
   output var  logic [7:0] port4_function_select_b
);

   // ***************************************************
   // Byte decode
   // ***************************************************
   function automatic logic sfr_arm(input logic [7:0] addr);
      return sfr_map_pkg::in_window(addr);
   endfunction : sfr_arm

   // Addresses below the window belong to internal RAM and are left alone
   wire       byte_wr_ok = sfr_wr && sfr_arm(sfr_addr);            // see (RQ1)
   wire       we_sp      = byte_wr_ok && sfr_addr == sfr_map_pkg::ADDR_STACK_POINTER;
   wire       we_dpl     = byte_wr_ok && sfr_addr == sfr_map_pkg::ADDR_DATA_POINTER_LOW;
   wire       we_dph     = byte_wr_ok && sfr_addr == sfr_map_pkg::ADDR_DATA_POINTER_HIGH;
   wire       we_psc     = byte_wr_ok && sfr_addr == sfr_map_pkg::ADDR_POINTER_SELECT_CTL;
   wire       we_psm     = byte_wr_ok && sfr_addr == sfr_map_pkg::ADDR_POINTER_STEP_MODE;
   wire       we_power_control    = byte_wr_ok && sfr_addr == sfr_map_pkg::ADDR_POWER_CONTROL;
   wire       we_timer_control    = byte_wr_ok && sfr_addr == sfr_map_pkg::ADDR_TIMER_CONTROL;
   wire       we_timer_mode    = byte_wr_ok && sfr_addr == sfr_map_pkg::ADDR_TIMER_MODE;
   wire       we_t0l     = byte_wr_ok && sfr_addr == sfr_map_pkg::ADDR_TIMER0_COUNT_LOW;
   wire       we_t1l     = byte_wr_ok && sfr_addr == sfr_map_pkg::ADDR_TIMER1_COUNT_LOW;
   wire       we_t0h     = byte_wr_ok && sfr_addr == sfr_map_pkg::ADDR_TIMER0_COUNT_HIGH;
   wire       we_t1h     = byte_wr_ok && sfr_addr == sfr_map_pkg::ADDR_TIMER1_COUNT_HIGH;
   wire       we_p1fa    = byte_wr_ok && sfr_addr == sfr_map_pkg::ADDR_PORT1_FSEL_A;
   wire       we_p1fb    = byte_wr_ok && sfr_addr == sfr_map_pkg::ADDR_PORT1_FSEL_B;
   wire       we_p1      = byte_wr_ok && sfr_addr == sfr_map_pkg::ADDR_PORT1_PINS;
   wire       we_p3f     = byte_wr_ok && sfr_addr == sfr_map_pkg::ADDR_PORT3_FSEL;
   wire       we_p4fa    = byte_wr_ok && sfr_addr == sfr_map_pkg::ADDR_PORT4_FSEL_A;
   wire       we_p4fb    = byte_wr_ok && sfr_addr == sfr_map_pkg::ADDR_PORT4_FSEL_B;

   // ***************************************************
   // Bit decode
   // ***************************************************
   // Only bytes at multiples of eight own bits; byte write takes priority
   wire [7:0] bit_byte   = sfr_map_pkg::bit_owner(bit_addr);        // see (RQ2)
   wire       bit_in_win = sfr_map_pkg::in_window(bit_addr);
   wire       bit_timer_control   = bit_in_win && bit_byte == sfr_map_pkg::ADDR_TIMER_CONTROL;
   wire       bit_p1     = bit_in_win && bit_byte == sfr_map_pkg::ADDR_PORT1_PINS;
   wire       bwe_timer_control   = bit_wr && !sfr_wr && bit_timer_control;           // see (RQ7)
   wire       bwe_p1     = bit_wr && !sfr_wr && bit_p1;
   wire [2:0] bit_sel    = bit_addr[2:0];

   // ***************************************************
   // Port pin synchroniser
   // ***************************************************
   logic [7:0] pin_meta_q;
   logic [7:0] pin_sync_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_q <= 8'h00;
         pin_sync_q <= 8'h00;
      end else begin
         pin_meta_q <= port1_pins_in;
         pin_sync_q <= pin_meta_q;
      end
   end

   // ***************************************************
   // Plain read/write registers
   // ***************************************************
   // Pointer-select and pointer-step registers drop reserved bits on write
   wire [7:0] psc_wdata = sfr_wdata & sfr_map_pkg::MASK_POINTER_SELECT;
   wire [7:0] psm_wdata = sfr_wdata & sfr_map_pkg::MASK_POINTER_STEP;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stack_pointer           <= sfr_map_pkg::RST_STACK_POINTER;  // see (RQ8)
         data_pointer_low        <= sfr_map_pkg::RST_ZERO;           // see (RQ6)
         data_pointer_high       <= sfr_map_pkg::RST_ZERO;
         pointer_select_control  <= sfr_map_pkg::RST_ZERO;
         pointer_step_mode       <= sfr_map_pkg::RST_ZERO;
         timer_mode              <= sfr_map_pkg::RST_ZERO;
         timer0_count_low        <= sfr_map_pkg::RST_ZERO;
         timer1_count_low        <= sfr_map_pkg::RST_ZERO;
         timer0_count_high       <= sfr_map_pkg::RST_ZERO;
         timer1_count_high       <= sfr_map_pkg::RST_ZERO;
         port1_function_select_a <= sfr_map_pkg::RST_ZERO;
         port1_function_select_b <= sfr_map_pkg::RST_ZERO;
         port3_function_select   <= sfr_map_pkg::RST_ZERO;
         port4_function_select_a <= sfr_map_pkg::RST_ZERO;
         port4_function_select_b <= sfr_map_pkg::RST_ZERO;
      end else begin
         if (we_sp)   stack_pointer           <= sfr_wdata;
         if (we_dpl)  data_pointer_low        <= sfr_wdata;
         if (we_dph)  data_pointer_high       <= sfr_wdata;
         if (we_psc)  pointer_select_control  <= psc_wdata;
         if (we_psm)  pointer_step_mode       <= psm_wdata;
         if (we_timer_mode) timer_mode              <= sfr_wdata;
         if (we_t0l)  timer0_count_low        <= sfr_wdata;
         if (we_t1l)  timer1_count_low        <= sfr_wdata;
         if (we_t0h)  timer0_count_high       <= sfr_wdata;
         if (we_t1h)  timer1_count_high       <= sfr_wdata;
         if (we_p1fa) port1_function_select_a <= sfr_wdata;
         if (we_p1fb) port1_function_select_b <= sfr_wdata;
         if (we_p3f)  port3_function_select   <= sfr_wdata;
         if (we_p4fa) port4_function_select_a <= sfr_wdata;
         if (we_p4fb) port4_function_select_b <= sfr_wdata;
      end
   end

   // ***************************************************
   // Flag registers
   // ***************************************************
   // Edge-type external interrupts lose their flag on acknowledge
   wire [7:0] timer_control_set = ({7'h00, timer1_overflow} << sfr_map_pkg::TC_TIMER1_OVERFLOW)
                       | ({7'h00, timer0_overflow} << sfr_map_pkg::TC_TIMER0_OVERFLOW)
                       | ({7'h00, ext_int1_event}  << sfr_map_pkg::TC_EXT_INT1_FLAG)
                       | ({7'h00, ext_int0_event}  << sfr_map_pkg::TC_EXT_INT0_FLAG);
   wire       ack1_clr = ext_int1_ack && timer_control[sfr_map_pkg::TC_EXT_INT1_TYPE];
   wire       ack0_clr = ext_int0_ack && timer_control[sfr_map_pkg::TC_EXT_INT0_TYPE];
   wire [7:0] timer_control_clr = ({7'h00, ack1_clr} << sfr_map_pkg::TC_EXT_INT1_FLAG)
                       | ({7'h00, ack0_clr} << sfr_map_pkg::TC_EXT_INT0_FLAG);
   wire [7:0] power_control_set = {7'h00, power_on_event} << sfr_map_pkg::PC_POWER_ON_FLAG;
   wire [7:0] power_control_clr = ({7'h00, wake_event} << sfr_map_pkg::PC_POWER_DOWN)
                       | ({7'h00, wake_event} << sfr_map_pkg::PC_IDLE);

   sfr_flag_reg #(
      .RESET_VALUE (sfr_map_pkg::RST_ZERO),
      .WRITE_MASK  (sfr_map_pkg::MASK_ALL)
   ) u_timer_control (
      .clock      (clock),
      .rst_n      (rst_n),
      .byte_we    (we_timer_control),
      .byte_wdata (sfr_wdata),
      .bit_we     (bwe_timer_control),                                        // see (RQ7)
      .bit_sel    (bit_sel),
      .bit_wdata  (bit_wdata),
      .hw_set     (timer_control_set),
      .hw_clr     (timer_control_clr),
      .value_q    (timer_control)
   );

   sfr_flag_reg #(
      .RESET_VALUE (sfr_map_pkg::RST_ZERO),
      .WRITE_MASK  (sfr_map_pkg::MASK_POWER_CONTROL)
   ) u_power_control (
      .clock      (clock),
      .rst_n      (rst_n),
      .byte_we    (we_power_control),
      .byte_wdata (sfr_wdata),
      .bit_we     (1'b0),
      .bit_sel    (3'h0),
      .bit_wdata  (1'b0),
      .hw_set     (power_control_set),
      .hw_clr     (power_control_clr),
      .value_q    (power_control)
   );

   // Bit writes modify the latch, not the pins, so read-modify-write is safe
   sfr_flag_reg #(
      .RESET_VALUE (sfr_map_pkg::RST_PORT1_LATCH),
      .WRITE_MASK  (sfr_map_pkg::MASK_ALL)
   ) u_port1_latch (
      .clock      (clock),
      .rst_n      (rst_n),
      .byte_we    (we_p1),
      .byte_wdata (sfr_wdata),
      .bit_we     (bwe_p1),
      .bit_sel    (bit_sel),
      .bit_wdata  (bit_wdata),
      .hw_set     (8'h00),
      .hw_clr     (8'h00),
      .value_q    (port1_latch)
   );

   // ***************************************************
   // Read path
   // ***************************************************
   // No port reaches the programmable-logic module's controls
   wire       rd_known = sfr_map_pkg::in_window(sfr_addr)            // see (RQ5)
                         && sfr_map_pkg::is_implemented(sfr_addr);
   wire [7:0] rd_lo    =
        sfr_addr == sfr_map_pkg::ADDR_STACK_POINTER      ? stack_pointer           :
        sfr_addr == sfr_map_pkg::ADDR_DATA_POINTER_LOW   ? data_pointer_low        :
        sfr_addr == sfr_map_pkg::ADDR_DATA_POINTER_HIGH  ? data_pointer_high       :
        sfr_addr == sfr_map_pkg::ADDR_POINTER_SELECT_CTL ? pointer_select_control  :
        sfr_addr == sfr_map_pkg::ADDR_POINTER_STEP_MODE  ? pointer_step_mode       :
        sfr_addr == sfr_map_pkg::ADDR_POWER_CONTROL      ? power_control           :
        sfr_addr == sfr_map_pkg::ADDR_TIMER_CONTROL      ? timer_control           :
        sfr_addr == sfr_map_pkg::ADDR_TIMER_MODE         ? timer_mode              :
        sfr_addr == sfr_map_pkg::ADDR_TIMER0_COUNT_LOW   ? timer0_count_low        :
        sfr_map_pkg::RESERVED_READ;
   wire [7:0] rd_hi    =
        sfr_addr == sfr_map_pkg::ADDR_TIMER1_COUNT_LOW   ? timer1_count_low        :
        sfr_addr == sfr_map_pkg::ADDR_TIMER0_COUNT_HIGH  ? timer0_count_high       :
        sfr_addr == sfr_map_pkg::ADDR_TIMER1_COUNT_HIGH  ? timer1_count_high       :
        sfr_addr == sfr_map_pkg::ADDR_PORT1_FSEL_A       ? port1_function_select_a :
        sfr_addr == sfr_map_pkg::ADDR_PORT1_FSEL_B       ? port1_function_select_b :
        sfr_addr == sfr_map_pkg::ADDR_PORT1_PINS         ? pin_sync_q              :
        sfr_addr == sfr_map_pkg::ADDR_PORT3_FSEL         ? port3_function_select   :
        sfr_addr == sfr_map_pkg::ADDR_PORT4_FSEL_A       ? port4_function_select_a :
        sfr_addr == sfr_map_pkg::ADDR_PORT4_FSEL_B       ? port4_function_select_b :
        sfr_map_pkg::RESERVED_READ;
   // Reserved reads carry no guaranteed value; hit low flags them
   wire [7:0] rd_byte  = rd_known ? (rd_lo | rd_hi) : sfr_map_pkg::RESERVED_READ; // see (RQ4)
   wire       bit_known = bit_timer_control || bit_p1;
   wire       rd_bit   = bit_timer_control ? timer_control[bit_sel] :
                         bit_p1   ? pin_sync_q[bit_sel]    : 1'b0;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rdata <= 8'h00;
         sfr_hit   <= 1'b0;
         bit_rdata <= 1'b0;
         bit_hit   <= 1'b0;
      end else begin
         if (sfr_rd) sfr_rdata <= rd_byte;
         sfr_hit   <= sfr_rd && rd_known;
         if (bit_rd) bit_rdata <= rd_bit;
         bit_hit   <= bit_rd && bit_known;                           // see (RQ2)
      end
   end

   // ***************************************************
   // Assertions
   // ***************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence reset_release;
      $rose(rst_n);
   endsequence

   sequence low_write;
      sfr_wr && !sfr_addr[7] && !bit_wr;
   endsequence

   wire [7:0] any_hw = {timer0_overflow, timer1_overflow, ext_int0_event, ext_int1_event,
                        ext_int0_ack, ext_int1_ack, power_on_event, wake_event};

   a_sp_reset_value: assert property (reset_release |-> stack_pointer == 8'h07) // see (RQ8)
      else $error("stack pointer not 07h after reset");
   a_regs_reset_zero: assert property (reset_release |->                       // see (RQ6)
         timer_control == 8'h00 && power_control == 8'h00 && timer_mode == 8'h00
         && pointer_select_control == 8'h00 && port4_function_select_b == 8'h00)
      else $error("register not zero after reset");
   a_low_addr_ignored: assert property (low_write ##0 (any_hw == 8'h00) |=>    // see (RQ1)
         $stable(stack_pointer) && $stable(timer_control) && $stable(timer_mode)
         && $stable(port1_latch) && $stable(power_control))
      else $error("write below window changed a register");
   a_byte_write_lands: assert property (sfr_wr && sfr_addr == 8'h89 |=>        // see (RQ1)
         timer_mode == $past(sfr_wdata))
      else $error("byte write to timer mode lost");
   a_timer_control_bit_map: assert property (bit_wr && !sfr_wr && bit_addr == 8'h8E     // see (RQ7)
         |=> timer_control[6] == $past(bit_wdata))
      else $error("bit 8Eh did not reach timer control bit 6");
   a_bit_only_owned: assert property (bit_wr && !sfr_wr && bit_addr[7]         // see (RQ2)
         && bit_addr[7:3] != 5'h11 && bit_addr[7:3] != 5'h12 && any_hw == 8'h00
         |=> $stable(timer_control) && $stable(port1_latch))
      else $error("bit write outside owned bytes changed state");
   a_reserved_no_hit: assert property (sfr_rd && sfr_addr == 8'h84             // see (RQ4)
         |=> !sfr_hit ##1 (!sfr_hit || $past(sfr_rd)))
      else $error("reserved address reported as implemented");
   a_overflow_set_wins: assert property (timer1_overflow && we_timer_control            // see (RQ6)
         |=> timer_control[7] [*1] ##0 power_control[5] == 1'b0)
      else $error("overflow lost to clearing write");
   a_read_returns_sp: assert property (sfr_rd && !sfr_wr && sfr_addr == 8'h81  // see (RQ1)
         |=> sfr_hit && sfr_rdata == $past(stack_pointer))
      else $error("stack pointer read mismatch");

endmodule : sfr_bank

`default_nettype wire

/* File: tb/core_model.sv */
// Core-side partner: issues direct byte and bit accesses to the register bank.
// Assumes the bench calls its tasks; signals change on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input  wire logic       clock,
   input  wire logic [7:0] sfr_rdata,
   input  wire logic       sfr_hit,
   input  wire logic       bit_rdata,
   input  wire logic       bit_hit,
   output var  logic [7:0] sfr_addr,
   output var  logic       sfr_rd,
   output var  logic       sfr_wr,
   output var  logic [7:0] sfr_wdata,
   output var  logic [7:0] bit_addr,
   output var  logic       bit_rd,
   output var  logic       bit_wr,
   output var  logic       bit_wdata
);
   initial begin
      {sfr_addr, sfr_rd, sfr_wr, sfr_wdata} = '0;
      {bit_addr, bit_rd, bit_wr, bit_wdata} = '0;
   end
   // Released lines show the inverse so stale values never pass for answers
   task automatic byte_op(input logic [7:0] a, input logic w, input logic [7:0] d,
                          output logic [7:0] q, output logic h);
      @(negedge clock);
      {sfr_addr, sfr_wr, sfr_rd, sfr_wdata} = {a, w, !w, d};
      @(negedge clock);
      {q, h} = {sfr_rdata, sfr_hit};
      {sfr_addr, sfr_wr, sfr_rd, sfr_wdata} = {~a, 2'b00, ~d};
   endtask : byte_op
   // Gap adds that many idle cycles before the access
   task automatic bit_op(input logic [7:0] a, input logic w, input logic d, input int gap,
                         output logic q, output logic h);
      repeat (gap) @(negedge clock);
      @(negedge clock);
      {bit_addr, bit_wr, bit_rd, bit_wdata} = {a, w, !w, d};
      @(negedge clock);
      {q, h} = {bit_rdata, bit_hit};
      {bit_addr, bit_wr, bit_rd, bit_wdata} = {~a, 2'b00, ~d};
   endtask : bit_op
endmodule : core_model
`default_nettype wire

/* File: tb/special_function_register_map_tb.sv */
// Self-checking bench for the register bank, driven through the core model.
// Assumes the bank answers reads one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module special_function_register_map_tb;
   logic       clock = 1'b0;
   logic       rst_n = 1'b0;
   logic [7:0] ev = 8'h00;
   logic [7:0] pins = 8'h3C;
   logic [7:0] q, tctl, a, p1l;
   logic       h, b, bh;
   wire  [7:0] addr, wd, baddr, rdata;
   wire        rd, wr, brd, bwr, bwd, hit, brdata, bhit;
   int         fail_count = 0;
   int         total_checks = 0;
   always #25 clock = ~clock;
   core_model i_core (.clock(clock), .sfr_rdata(rdata), .sfr_hit(hit), .bit_rdata(brdata),
      .bit_hit(bhit), .sfr_addr(addr), .sfr_rd(rd), .sfr_wr(wr), .sfr_wdata(wd),
      .bit_addr(baddr), .bit_rd(brd), .bit_wr(bwr), .bit_wdata(bwd));
   sfr_bank i_dut (.clock(clock), .rst_n(rst_n), .sfr_addr(addr), .sfr_rd(rd), .sfr_wr(wr),
      .sfr_wdata(wd), .sfr_rdata(rdata), .sfr_hit(hit), .bit_addr(baddr), .bit_rd(brd),
      .bit_wr(bwr), .bit_wdata(bwd), .bit_rdata(brdata), .bit_hit(bhit),
      .timer0_overflow(ev[0]), .timer1_overflow(ev[1]), .ext_int0_event(ev[2]),
      .ext_int1_event(ev[3]), .ext_int0_ack(ev[4]), .ext_int1_ack(ev[5]),
      .power_on_event(ev[6]), .wake_event(ev[7]), .port1_pins_in(pins),
      .stack_pointer(), .data_pointer_low(), .data_pointer_high(), .pointer_select_control(),
      .pointer_step_mode(), .power_control(), .timer_control(tctl), .timer_mode(),
      .timer0_count_low(), .timer1_count_low(), .timer0_count_high(), .timer1_count_high(),
      .port1_function_select_a(), .port1_function_select_b(), .port1_latch(p1l),
      .port3_function_select(), .port4_function_select_a(), .port4_function_select_b());
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t ns: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic logic [7:0] wmask(input logic [7:0] x);
      case (x)
         sfr_map_pkg::ADDR_POINTER_SELECT_CTL: return sfr_map_pkg::MASK_POINTER_SELECT;
         sfr_map_pkg::ADDR_POINTER_STEP_MODE:  return sfr_map_pkg::MASK_POINTER_STEP;
         sfr_map_pkg::ADDR_POWER_CONTROL:      return sfr_map_pkg::MASK_POWER_CONTROL;
         default:                              return 8'hFF;
      endcase
   endfunction : wmask
   // ***************************************************
   // Scenarios
   // ***************************************************
   task automatic reset_values();
      i_core.byte_op(8'h81, 1'b0, 8'h00, q, h);
      check(q, sfr_map_pkg::RST_STACK_POINTER);
      check(p1l, sfr_map_pkg::RST_PORT1_LATCH);
      for (a = 8'h82; a <= 8'h93; a++) begin
         if (a == 8'h84 || a == 8'h90) continue;
         i_core.byte_op(a, 1'b0, 8'h00, q, h);
         check(q, 8'h00);
      end
   endtask : reset_values
   task automatic byte_access();
      for (a = 8'h81; a <= 8'h93; a++) begin
         if (a == 8'h84 || a == 8'h90) continue;
         i_core.byte_op(a, 1'b1, a ^ 8'hA5, q, h);
         i_core.byte_op(a, 1'b0, 8'h00, q, h);
         check(q, (a ^ 8'hA5) & wmask(a));
         check({7'h00, h}, 8'h01);
      end
      // Pin levels come back through the synchroniser, not the latch
      i_core.byte_op(8'h90, 1'b0, 8'h00, q, h);
      check(q, 8'h3C);
   endtask : byte_access
   task automatic reserved_access();
      // Reserved bytes are only read, never written
      i_core.byte_op(8'h84, 1'b0, 8'h00, q, h);
      check({7'h00, h}, 8'h00);
      i_core.byte_op(8'h0A, 1'b1, 8'h77, q, h);
      i_core.byte_op(8'h8A, 1'b0, 8'h00, q, h);
      check(q, 8'h8A ^ 8'hA5);
   endtask : reserved_access
   task automatic bit_access();
      i_core.byte_op(8'h88, 1'b1, 8'h00, q, h);
      for (int n = 0; n < 8; n++) begin
         i_core.bit_op(8'h88 + 8'(n), 1'b1, 1'b1, n % 3, b, bh);
         check(tctl, 8'((16'h0002 << n) - 16'h0001));
         i_core.bit_op(8'h88 + 8'(n), 1'b0, 1'b0, 0, b, bh);
         check({6'h00, b, bh}, 8'h03);
      end
      i_core.bit_op(8'h81, 1'b0, 1'b0, 0, b, bh);
      check({7'h00, bh}, 8'h00);
      i_core.bit_op(8'hA0, 1'b1, 1'b1, 0, b, bh);
      check(tctl, 8'hFF);
      i_core.bit_op(8'h93, 1'b1, 1'b0, 0, b, bh);
      check(p1l, 8'hF7);
      i_core.bit_op(8'h92, 1'b0, 1'b0, 0, b, bh);
      check({6'h00, b, bh}, 8'h03);
   endtask : bit_access
   task automatic hw_events();
      // Overflow and power-on pulses meet a clearing write in one cycle
      fork
         i_core.byte_op(8'h88, 1'b1, 8'h00, q, h);
         begin
            @(negedge clock);
            ev = 8'h42;
            @(negedge clock);
            ev = 8'h00;
         end
      join
      check(tctl, 8'h80);
      i_core.byte_op(8'h87, 1'b0, 8'h00, q, h);
      check(q, 8'h12);
   endtask : hw_events
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report
   initial begin
      repeat (10) @(negedge clock);
      rst_n = 1'b1;
      reset_values();
      byte_access();
      reserved_access();
      bit_access();
      hw_events();
      final_report();
   end
   initial begin
      #(50 * 3000);
      fail_count++;
      final_report();
   end
endmodule : special_function_register_map_tb
`default_nettype wire
